// file: lia_pkg.sv
// Purpose: Shared constants for the link interrupt aggregator
// Assumes: AHB-Lite slave, 32-bit words, one aligned word per register
// Notes:   Byte offsets are the printed ones, all multiples of four
package lia_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  LIA_OFF_STATUS  = 8'h0c;  // Interrupt status
  localparam logic [7:0]  LIA_OFF_MASK    = 8'h10;  // Interrupt enable mask
  localparam logic [7:0]  LIA_OFF_CTRL    = 8'h40;  // Local control word
  localparam logic [7:0]  LIA_ADDR_MASK   = 8'hfc;  // Word alignment mask

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LIA_BIT_SUMMARY   = 0;   // Summary bit in status
  localparam int LIA_BIT_PHY       = 1;   // PHY chip interrupt
  localparam int LIA_BIT_PHYREG    = 2;   // PHY register value received
  localparam int LIA_BIT_BUSRST    = 3;   // Bus reset begun
  localparam int LIA_BIT_SIDDONE   = 4;   // Bus reset process finished
  localparam int LIA_BIT_TXIDLE    = 5;   // Transmitter idle
  localparam int LIA_BIT_RXBLOCK   = 6;   // Receive block accepted
  localparam int LIA_BIT_RSTCMD    = 7;   // Reset command received
  localparam int LIA_BIT_ACK_ARRIVED_FLAG    = 8;   // Ack arrived or timed out
  localparam int LIA_BIT_ACKDROP   = 9;   // Ack dropped, FIFO full
  localparam int LIA_NUM_EVENTS    = 9;   // Event inputs, bits 1..9
  localparam int LIA_CTRL_DIAG     = 0;   // Diagnostic direct access
  localparam int LIA_CTRL_SUMEN    = 1;   // Summary enable to pin
  localparam int LIA_CTRL_FLUSH    = 2;   // Drop bad packets
  localparam int LIA_CTRL_PART     = 3;   // Block partition enable
  localparam int LIA_CTRL_SIDCAP   = 4;   // Self-ID capture enable

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] LIA_RST_STATUS = 32'h0000_0000;  // All clear
  localparam logic [31:0] LIA_RST_MASK   = 32'h0000_0000;  // All disabled
  localparam logic [4:0]  LIA_RST_CTRL   = 5'h00;          // All off

  // AHB transfer type code for a non-sequential transfer
  localparam logic [1:0]  LIA_HTRANS_NONSEQ = 2'h2;

  // Summary: OR over bits 1..31 of status AND mask
  function automatic logic lia_summary(input logic [31:0] st,
                                       input logic [31:0] mk);
    lia_summary = |(st[31:1] & mk[31:1]);
  endfunction

endpackage

// file: lia_event_gate.sv
// Purpose: Qualifies raw receiver events by the flush and partition modes
// Assumes: Event strobes are one-cycle pulses synchronous to REF_CLK
// Notes:   Registered, so gated events lag the raw strobes by one cycle
`timescale 1ns/1ps
module lia_event_gate
  import lia_pkg::*;
(
  input  wire logic       clk,           // Block clock
  input  wire logic       rst,           // Synchronous reset, high
  input  wire logic       ce,            // Clock enable
  input  wire logic       flush_en,      // Drop bad packets mode
  input  wire logic       part_en,       // Block partition mode
  input  wire logic       blk_done,      // Trigger-size block accepted
  input  wire logic       pkt_done,      // Whole packet accepted, good or bad
  input  wire logic       pkt_bad,       // Packet ended bad or partial
  input  wire logic       sid_done,      // One self-ID accepted
  output logic            rx_event       // Qualified receive event
);

  logic rx_ev_ff;   // Registered receive event
  logic nxt_rx_ev;  // Next receive event

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  // Flushing also disables partitioning, so a bad packet never
  // leaks a partial block
  always_comb begin
    logic part_eff;
    part_eff = part_en & ~flush_en;
    nxt_rx_ev = sid_done;
    if (part_eff && blk_done) begin
      nxt_rx_ev = 1'b1;
    end
    if (pkt_done && !(pkt_bad && flush_en)) begin
      nxt_rx_ev = 1'b1;
    end
  end

  // Register the event
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_ev_ff <= 1'b0;
    end else if (ce) begin
      rx_ev_ff <= nxt_rx_ev;
    end
  end

  assign rx_event = rx_ev_ff;

  chk_flush_drops_bad: assert property (@(posedge clk) disable iff (rst)
    ce && flush_en && pkt_bad && pkt_done && !sid_done && !blk_done
      |=> !rx_event)
    else $error("Bad packet raised receive event while flushing");

endmodule

// file: lia_ahb_slave.sv
// Purpose: AHB-Lite slave front end turning transfers into strobes
// Assumes: Single word transfers only, slave always OKAY, no waits
// Notes:   Write strobe fires in the data phase with HWDATA valid
`timescale 1ns/1ps
module lia_ahb_slave
  import lia_pkg::*;
(
  input  wire logic        clk,          // Block clock
  input  wire logic        rst,          // Synchronous reset, high
  input  wire logic        ce,           // Clock enable
  input  wire logic        hsel,         // Slave select
  input  wire logic [1:0]  htrans,       // Transfer type
  input  wire logic        hwrite,       // Write when high
  input  wire logic [7:0]  haddr,        // Low address bits
  input  wire logic        hready,       // Bus ready
  output logic             wr_stb,       // Write strobe, data phase
  output logic             rd_stb,       // Read strobe, address phase
  output logic [7:0]       acc_addr      // Word address of access
);

  logic       wr_ff;     // Pending write data phase
  logic       nxt_wr;    // Next pending write
  logic [7:0] addr_ff;   // Latched write address
  logic [7:0] nxt_addr;  // Next latched address
  logic       valid_ap;  // Valid address phase

  // ----------------------------------------------------------------
  // Address phase capture
  // ----------------------------------------------------------------
  always_comb begin
    valid_ap = hsel && hready && (htrans == LIA_HTRANS_NONSEQ);
    nxt_wr   = valid_ap && hwrite;
    nxt_addr = valid_ap ? (haddr & LIA_ADDR_MASK) : addr_ff;
  end

  // Register the address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff   <= 1'b0;
      addr_ff <= 8'h00;
    end else if (ce) begin
      wr_ff   <= nxt_wr;
      addr_ff <= nxt_addr;
    end
  end

  assign wr_stb   = wr_ff;
  assign rd_stb   = valid_ap && !hwrite;
  assign acc_addr = rd_stb ? (haddr & LIA_ADDR_MASK) : addr_ff;

endmodule

// file: lia_top.sv
// Purpose: Interrupt status and mask aggregator of a serial-bus link layer
// Assumes: Event inputs are one-cycle pulses synchronous to REF_CLK
// Notes:   Status clears by writing back the value read; AHB-Lite access
//          Status, mask and control word all reset to zero
`timescale 1ns/1ps
module lia_top
  import lia_pkg::*;
(
  input  wire logic        REF_CLK,         // 250 MHz block clock
  input  wire logic        RESET,           // Synchronous reset, high
  input  wire logic        CE,              // Clock enable, freezes all
  input  wire logic        HSEL,            // AHB slave select
  input  wire logic [31:0] HADDR,           // AHB address
  input  wire logic [1:0]  HTRANS,          // AHB transfer type
  input  wire logic        HWRITE,          // AHB write
  input  wire logic [2:0]  HSIZE,           // AHB size, word only
  input  wire logic [31:0] HWDATA,          // AHB write data
  input  wire logic        HREADY,          // AHB bus ready
  output logic [31:0]      HRDATA,          // AHB read data
  output logic             HREADYOUT,       // AHB slave ready
  output logic             HRESP,           // AHB response, always OKAY
  input  wire logic        PHY_EVENT,       // PHY chip interrupt pulse
  input  wire logic        PHY_REG_LOADED,  // PHY access register loaded
  input  wire logic        BUS_RESET_START, // Bus reset has begun
  input  wire logic        BUS_RESET_DONE,  // Bus reset process done
  input  wire logic        TX_IDLE,         // Transmitter became idle
  input  wire logic        RX_BLOCK_DONE,   // Trigger-size block accepted
  input  wire logic        RX_PKT_DONE,     // Whole packet accepted
  input  wire logic        RX_PKT_BAD,      // Packet bad or partial
  input  wire logic        SELF_ID_DONE,    // One self-ID accepted
  input  wire logic        RESET_CMD,       // Reset command write seen
  input  wire logic        ACK_ARRIVED,     // Ack received or timed out
  input  wire logic        ACK_DROPPED,     // Ack dropped, FIFO full
  output logic             INT_OUT,         // Interrupt to host, high
  output logic             DROP_BAD_PACKETS,// Flush mode to receiver
  output logic             BLOCK_PARTITION, // Partition mode to receiver
  output logic             SELF_ID_CAPTURE  // Self-ID capture to receiver
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] status_ff;      // Interrupt status register
  logic [31:0] nxt_status;     // Next status
  logic [31:0] mask_ff;        // Interrupt enable mask
  logic [31:0] nxt_mask;       // Next mask
  logic [4:0]  ctrl_ff;        // Local control word
  logic [4:0]  nxt_ctrl;       // Next control word
  logic [31:0] rdata_ff;       // Read data register
  logic [31:0] nxt_rdata;      // Next read data
  logic        int_ff;         // Interrupt pin register
  logic        nxt_int;        // Next interrupt pin
  logic [31:0] ev_set;         // Event set vector
  logic        rx_event;       // Qualified receive event
  logic        wr_stb;         // Register write strobe
  logic        rd_stb;         // Register read strobe
  logic [7:0]  acc_addr;       // Accessed word address
  logic        diag;           // Diagnostic direct access
  logic        sum_en;         // Summary enable to pin
  logic        nxt_drop;       // Next flush mode output
  logic        nxt_part;       // Next partition mode output
  logic        nxt_sidc;       // Next self-ID capture output

  assign diag   = ctrl_ff[LIA_CTRL_DIAG];
  assign sum_en = ctrl_ff[LIA_CTRL_SUMEN];

  // ----------------------------------------------------------------
  // Bus front end and receive event qualifier
  // ----------------------------------------------------------------
  lia_ahb_slave u_bus (
    .clk      (REF_CLK),
    .rst      (RESET),
    .ce       (CE),
    .hsel     (HSEL),
    .htrans   (HTRANS),
    .hwrite   (HWRITE),
    .haddr    (HADDR[7:0]),
    .hready   (HREADY),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb),
    .acc_addr (acc_addr)
  );

  lia_event_gate u_rx (
    .clk      (REF_CLK),
    .rst      (RESET),
    .ce       (CE),
    .flush_en (ctrl_ff[LIA_CTRL_FLUSH]),
    .part_en  (ctrl_ff[LIA_CTRL_PART]),
    .blk_done (RX_BLOCK_DONE),
    .pkt_done (RX_PKT_DONE),
    .pkt_bad  (RX_PKT_BAD),
    .sid_done (SELF_ID_DONE),
    .rx_event (rx_event)
  );

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  // Bits above 9 have no source here; they stay clear outside diag
  always_comb begin
    ev_set                  = 32'h0000_0000;
    ev_set[LIA_BIT_PHY]     = PHY_EVENT;
    ev_set[LIA_BIT_PHYREG]  = PHY_REG_LOADED;
    ev_set[LIA_BIT_BUSRST]  = BUS_RESET_START;
    ev_set[LIA_BIT_SIDDONE] = BUS_RESET_DONE;
    ev_set[LIA_BIT_TXIDLE]  = TX_IDLE;
    ev_set[LIA_BIT_RXBLOCK] = rx_event;
    ev_set[LIA_BIT_RSTCMD]  = RESET_CMD;
    ev_set[LIA_BIT_ACK_ARRIVED_FLAG]  = ACK_ARRIVED;
    ev_set[LIA_BIT_ACKDROP] = ACK_DROPPED;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Data-phase write hit on one register offset
  function automatic logic lia_hit(input logic       stb,
                                   input logic [7:0] addr,
                                   input logic [7:0] off);
    lia_hit = stb && (addr == off);
  endfunction

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  // One process for status, mask, control and pin state, so the summary sees the same
  // status and mask that will be stored at this edge
  always_comb begin
    logic [31:0] held;
    logic        wr_st;
    logic        wr_mk;
    wr_st     = lia_hit(wr_stb, acc_addr, LIA_OFF_STATUS);
    wr_mk     = lia_hit(wr_stb, acc_addr, LIA_OFF_MASK);
    held      = status_ff;
    nxt_mask  = mask_ff;
    nxt_ctrl  = ctrl_ff;
    if (wr_st && diag) begin
      held = HWDATA;
    end else if (wr_st) begin
      // Write-one-to-clear so events after the read stay pending
      held = status_ff & ~HWDATA;
    end
    // Set wins over a clear in the same cycle
    nxt_status = held | ev_set;
    if (wr_mk) begin
      nxt_mask = HWDATA;
    end
    if (lia_hit(wr_stb, acc_addr, LIA_OFF_CTRL)) begin
      nxt_ctrl = HWDATA[4:0];
    end
    // Summary comes from the new status and new mask, so a pending
    // masked bit raises it again at once; diag mode keeps it stored
    if (!diag) begin
      nxt_status[LIA_BIT_SUMMARY] = lia_summary(nxt_status, nxt_mask);
    end
    nxt_int = nxt_status[LIA_BIT_SUMMARY] && nxt_ctrl[LIA_CTRL_SUMEN];
  end

  // Mode outputs follow the control word written at this edge; flush
  // overrides partitioning so a bad packet leaves no stray block
  always_comb begin
    nxt_drop = nxt_ctrl[LIA_CTRL_FLUSH];
    nxt_part = nxt_ctrl[LIA_CTRL_PART] & ~nxt_ctrl[LIA_CTRL_FLUSH];
    nxt_sidc = nxt_ctrl[LIA_CTRL_SIDCAP];
  end

  // Read mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_stb) begin
      case (acc_addr)
        LIA_OFF_STATUS: nxt_rdata = status_ff;
        LIA_OFF_MASK:   nxt_rdata = mask_ff;
        LIA_OFF_CTRL:   nxt_rdata = {27'h000_0000, ctrl_ff};
        default:        nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      status_ff <= LIA_RST_STATUS;
      mask_ff   <= LIA_RST_MASK;
      ctrl_ff   <= LIA_RST_CTRL;
      rdata_ff  <= 32'h0000_0000;
      int_ff    <= 1'b0;
    end else if (CE) begin
      status_ff <= nxt_status;
      mask_ff   <= nxt_mask;
      ctrl_ff   <= nxt_ctrl;
      rdata_ff  <= nxt_rdata;
      int_ff    <= nxt_int;
    end
  end

  // Output flops; responses are constant, slave never waits
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      HREADYOUT        <= 1'b1;
      HRESP            <= 1'b0;
      DROP_BAD_PACKETS <= 1'b0;
      BLOCK_PARTITION  <= 1'b0;
      SELF_ID_CAPTURE  <= 1'b0;
    end else if (CE) begin
      HREADYOUT        <= 1'b1;
      HRESP            <= 1'b0;
      DROP_BAD_PACKETS <= nxt_drop;
      BLOCK_PARTITION  <= nxt_part;
      SELF_ID_CAPTURE  <= nxt_sidc;
    end
  end

  assign HRDATA  = rdata_ff;
  assign INT_OUT = int_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mask_write_read: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && wr_stb && acc_addr == LIA_OFF_MASK |=> mask_ff == $past(HWDATA))
    else $error("Mask write not stored");

  chk_clear_normal: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && wr_stb && acc_addr == LIA_OFF_STATUS && !diag
      |=> (status_ff[31:1] & $past(HWDATA[31:1]) & ~$past(ev_set[31:1])) == 31'h0)
    else $error("Written one did not clear status");

  chk_diag_store: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && wr_stb && acc_addr == LIA_OFF_STATUS && diag
      |=> status_ff == ($past(HWDATA) | $past(ev_set)))
    else $error("Diagnostic write not stored");

  chk_event_sets: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && PHY_EVENT |=> status_ff[LIA_BIT_PHY])
    else $error("PHY event did not set status");

  chk_summary_or: assert property (@(posedge REF_CLK) disable iff (RESET)
    !diag && !$past(diag) && $past(CE) && status_ff[31:1] == 31'h0
      |-> !status_ff[LIA_BIT_SUMMARY])
    else $error("Summary set with all status bits clear");

  chk_summary_eq: assert property (@(posedge REF_CLK) disable iff (RESET)
    !diag && $past(CE) && !$past(diag) && !$past(wr_stb)
      |-> status_ff[0] == lia_summary(status_ff, mask_ff))
    else $error("Summary does not match masked status");

  chk_pin_gated: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE |=> INT_OUT == (status_ff[0] && sum_en))
    else $error("Interrupt pin does not follow summary");

  chk_ack_drop: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && ACK_DROPPED ##1 !CE [*2] |-> status_ff[LIA_BIT_ACKDROP])
    else $error("Ack drop flag lost while frozen");

  chk_reset_zero: assert property (@(posedge REF_CLK)
    RESET |=> status_ff == 32'h0000_0000 && !INT_OUT)
    else $error("Status not zero after reset");

  chk_zero_keeps: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && wr_stb && acc_addr == LIA_OFF_STATUS && !diag
      |=> (~status_ff[31:1] & $past(status_ff[31:1]) & ~$past(HWDATA[31:1])) == 31'h0)
    else $error("Written zero cleared a status bit");

  chk_events_all: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE |=> ($past(ev_set[31:1]) & ~status_ff[31:1]) == 31'h0)
    else $error("Event did not set its status bit");

  chk_pin_on: assert property (@(posedge REF_CLK) disable iff (RESET)
    status_ff[LIA_BIT_SUMMARY] && sum_en |-> INT_OUT)
    else $error("Interrupt pin low with enabled summary");

  chk_rx_sets: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && rx_event |=> status_ff[LIA_BIT_RXBLOCK])
    else $error("Receive event did not set status");

  chk_ack_sets: assert property (@(posedge REF_CLK) disable iff (RESET)
    CE && ACK_ARRIVED |=> status_ff[LIA_BIT_ACK_ARRIVED_FLAG])
    else $error("Ack arrival did not set status");

endmodule

// file: lia_host_model.sv
// Purpose: Host processor model, an AHB-Lite master of single words
// Assumes: One slave, so HREADY is that slave's HREADYOUT
// Notes:   Released write data shows the inverse of its last value
`timescale 1ns/1ps
module lia_host_model
  import lia_pkg::*;
(
  input  wire logic        clk,     // Bus clock
  input  wire logic        hready,  // Bus ready
  input  wire logic [31:0] hrdata,  // Read data
  output logic             hsel,    // Slave select
  output logic [31:0]      haddr,   // Address
  output logic [1:0]       htrans,  // Transfer type
  output logic             hwrite,  // Write when high
  output logic [2:0]       hsize,   // Always a word
  output logic [31:0]      hwdata   // Write data
);
  // --------------------------------------------------------------
  // Idle bus at time zero
  // --------------------------------------------------------------
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // One transfer; entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= LIA_HTRANS_NONSEQ;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    hwdata <= ~wd;
    // Idle gap: one more cycle before the caller resumes or starts the next transfer
    @(posedge clk);
  endtask

  // Clear pending bits by writing back what was read
  task automatic clear_pending(output logic [31:0] v);
    logic [31:0] d;
    xfer(1'b0, LIA_OFF_STATUS, 32'h0000_0000, v);
    xfer(1'b1, LIA_OFF_STATUS, v, d);
  endtask
endmodule

// file: test_link_interrupt_aggregator.sv
// Purpose: Self-checking bench of the interrupt aggregator
// Assumes: Host model drives the bus, bench drives event pulses
// Notes:   Clock enable drops in one scenario to check freezing
`timescale 1ns/1ps
module test_link_interrupt_aggregator
  import lia_pkg::*;
;
  logic        clk = 1'b0;       // 250 MHz clock
  logic        rst = 1'b1;       // Synchronous reset
  logic        ce = 1'b1;        // Clock enable
  logic [12:1] ev = '0;          // 1..9 status events, 10 blk, 11 bad, 12 sid
  logic        hsel, hwrite, hready, hresp, int_out, drop, part, sidc;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          failures = 0;     // Mismatches
  int          checks = 0;       // Comparisons

  always #2 clk = ~clk;

  lia_host_model i_lia_host_model (.clk(clk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  lia_top i_lia_top (.REF_CLK(clk), .RESET(rst), .CE(ce), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .PHY_EVENT(ev[1]), .PHY_REG_LOADED(ev[2]),
    .BUS_RESET_START(ev[3]), .BUS_RESET_DONE(ev[4]), .TX_IDLE(ev[5]),
    .RX_BLOCK_DONE(ev[10]), .RX_PKT_DONE(ev[6]), .RX_PKT_BAD(ev[11]),
    .SELF_ID_DONE(ev[12]), .RESET_CMD(ev[7]), .ACK_ARRIVED(ev[8]),
    .ACK_DROPPED(ev[9]), .INT_OUT(int_out), .DROP_BAD_PACKETS(drop),
    .BLOCK_PARTITION(part), .SELF_ID_CAPTURE(sidc));

  // --------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    i_lia_host_model.xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    i_lia_host_model.xfer(1'b0, a, 32'h0000_0000, d);
  endtask

  // One-cycle pulse on events b and c together (c of 0 means none),
  // then time for the gated path to land
  task automatic pulse_pair(input int b, input int c);
    logic [12:0] m;
    m    = '0;
    m[b] = 1'b1;
    m[c] = 1'b1;
    ev <= m[12:1];
    @(posedge clk);
    ev <= '0;
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse(input int b);
    pulse_pair(b, 0);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] v;
    rd(LIA_OFF_STATUS, v);
    chk("status reset", v, 32'h0000_0000);
    rd(LIA_OFF_MASK, v);
    chk("mask reset", v, 32'h0000_0000);
    chk("pins reset", {int_out, drop, part, sidc, hresp}, 32'h0000_0000);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, v);
    chk("unmapped", v, 32'h0000_0000);
    $display("t_reset done");
  endtask

  task automatic t_mask();
    logic [31:0] pat[3] = '{32'hFFFF_FFFF, 32'hA5A5_5A5A, 32'h0000_0000};
    logic [31:0] v;
    foreach (pat[i]) begin
      wr(LIA_OFF_MASK, pat[i]);
      rd(LIA_OFF_MASK, v);
      chk("mask rw", v, pat[i]);
    end
    $display("t_mask done");
  endtask

  task automatic t_events();
    logic [31:0] v, e;
    e = 32'h0000_0000;
    for (int b = 1; b <= 9; b++) begin
      pulse(b);
      e[b] = 1'b1;
      rd(LIA_OFF_STATUS, v);
      chk("event bit", v, e);
    end
    wr(LIA_OFF_MASK, 32'h0000_0004);
    rd(LIA_OFF_STATUS, v);
    chk("summary", v, e | 32'h0000_0001);
    chk("pin off", int_out, 1'b0);
    wr(LIA_OFF_CTRL, 32'h0000_0002);
    chk("pin on", int_out, 1'b1);
    i_lia_host_model.clear_pending(v);
    rd(LIA_OFF_STATUS, v);
    chk("cleared", v, 32'h0000_0000);
    chk("pin clear", int_out, 1'b0);
    $display("t_events done");
  endtask

  task automatic t_race();
    logic [31:0] v, x;
    wr(LIA_OFF_MASK, 32'h0000_03FE);
    pulse(1);
    pulse(5);
    rd(LIA_OFF_STATUS, v);
    pulse(3);
    wr(LIA_OFF_STATUS, v);
    rd(LIA_OFF_STATUS, x);
    chk("late event kept", x, 32'h0000_0009);
    chk("pin held", int_out, 1'b1);
    wr(LIA_OFF_STATUS, 32'h0000_0000);
    wr(LIA_OFF_STATUS, 32'h0000_0001);
    rd(LIA_OFF_STATUS, x);
    chk("no store", x, 32'h0000_0009);
    i_lia_host_model.clear_pending(v);
    $display("t_race done");
  endtask

  task automatic t_diag();
    logic [31:0] v;
    wr(LIA_OFF_CTRL, 32'h0000_0001);
    wr(LIA_OFF_STATUS, 32'h8000_0001);
    rd(LIA_OFF_STATUS, v);
    chk("diag store", v, 32'h8000_0001);
    wr(LIA_OFF_STATUS, 32'h0000_0000);
    rd(LIA_OFF_STATUS, v);
    chk("diag zero", v, 32'h0000_0000);
    wr(LIA_OFF_CTRL, 32'h0000_0000);
    $display("t_diag done");
  endtask

  task automatic t_rx();
    logic [31:0] v;
    wr(LIA_OFF_CTRL, 32'h0000_001C);
    chk("flush modes", {drop, part, sidc}, 3'b101);
    // Packet end flagged bad: must not count as received data
    pulse_pair(6, 11);
    rd(LIA_OFF_STATUS, v);
    chk("bad dropped", v, 32'h0000_0000);
    wr(LIA_OFF_CTRL, 32'h0000_0008);
    chk("part mode", {drop, part}, 2'b01);
    pulse(10);
    i_lia_host_model.clear_pending(v);
    chk("block event", v, 32'h0000_0041);
    pulse(12);
    rd(LIA_OFF_STATUS, v);
    chk("self id", v, 32'h0000_0041);
    $display("t_rx done");
  endtask

  // An event seen with CE high lands; one seen while CE is low is lost
  task automatic t_freeze();
    logic [31:0] v;
    i_lia_host_model.clear_pending(v);
    ev[9] <= 1'b1;
    @(posedge clk);
    ev[9] <= 1'b0;
    ce    <= 1'b0;
    @(posedge clk);
    ev[1] <= 1'b1;
    @(posedge clk);
    ev[1] <= 1'b0;
    @(posedge clk);
    ce    <= 1'b1;
    rd(LIA_OFF_STATUS, v);
    chk("freeze", v, 32'h0000_0201);
    $display("t_freeze done");
  endtask

  // --------------------------------------------------------------
  // Verdict and run control
  // --------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_mask();
    t_events();
    t_race();
    t_diag();
    t_rx();
    t_freeze();
    end_of_test();
  end

  // Watchdog: the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
